/* File: mtr_tuning_regs.sv */
// Function
// RL1 - report sixteen-bit process rate, low below 0080h
// RL2 - software reads sixteen-bit pairs atomically
// RL3 - average converter samples by sample size
// RL4 - debounce time sets wait, 01h to FFh
// RL5 - debounce below sensitivity means no motion
// RL6 - batch mask counts consecutive out-of-window samples
// RL7 - transient field bits 6-0, zero disables
// RL8 - noise field bits 6-0, zero disables
// RL9 - software limits noise value by window
// RL10 - new sample stored, new-sample flag set
// RL11 - new limits store DC level pair
// RL12 - sensitivity bit seven reads zero
// RL13 - device sets new-sample flag, software clears
// RL14 - window size codes small, medium, large
//
// Chosen here: the Wishbone slave port.
module mtr_tuning_regs
	import mtr_pkg::*;
#(
	parameter logic [15:0] WIN_SMALL_WIDTH = 16'h0040,
	parameter logic [15:0] WIN_MEDIUM_WIDTH = 16'h0080,
	parameter logic [15:0] WIN_LARGE_WIDTH = 16'h0100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic adc_valid_i,
	input wire logic [15:0] adc_i,
	input wire logic dc_valid_i,
	input wire logic [15:0] dc_i,
	input wire logic [15:0] process_rate_i,
	output logic rate_low_o,
	output logic motion_o,
	output logic irq_o
);

	// ****************************************
	// storage
	// ****************************************
	logic [7:0] sample_averaging_size; // averaging amount
	logic [7:0] debounce_time; // debounce wait
	logic [7:0] debounce_batch_mask; // batch mask
	logic [7:0] transient_sensitivity; // bits 6-0 only used
	logic [7:0] noise_sensitivity; // bits 6-0 only used
	logic [7:0] motion_sensitivity; // compared with debounce time
	logic [7:0] advanced_control_two; // lock, window size, update rate
	logic [7:0] irq_mask; // interrupt enables
	logic [7:0] status; // sticky event flags
	logic [15:0] sensor_sample_value; // last averaged sample
	logic [15:0] sensor_dc_level; // last dc level
	logic [15:0] engine_process_rate; // sampled process rate
	logic [7:0] low_shadow; // low byte captured on high read
	logic [15:0] prev_sample; // previous sample for deltas
	logic [16:0] prev_delta; // previous signed delta
	logic have_prev; // a previous sample exists

	// ****************************************
	// sub blocks
	// ****************************************
	mtr_sample_if avg_bus ();
	wire motion_pulse; // debounced motion event
	wire out_of_window; // sample outside control window

	// averages raw converter samples
	mtr_averager u_avg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.adc_valid_i(adc_valid_i),
		.adc_i(adc_i),
		.size_i(sample_averaging_size),
		.out(avg_bus.src)
	);

	// debounces window excursions into motion
	mtr_debounce u_deb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sample_valid_i(avg_bus.valid),
		.out_of_window_i(out_of_window),
		.batch_mask_i(debounce_batch_mask),
		.debounce_time_i(debounce_time),
		.sensitivity_i(motion_sensitivity),
		.motion_o(motion_pulse)
	);

	// ****************************************
	// engine side decode
	// ****************************************
	// magnitude of a signed 17-bit difference, saturated to 16 bits
	function automatic logic [15:0] mag17(input logic [16:0] d);
		logic [16:0] m;
		m = d[16] ? (17'h00000 - d) : d;
		return m[16] ? 16'hFFFF : m[15:0];
	endfunction : mag17

	wire [15:0] new_sample = avg_bus.data; // incoming average
	wire [16:0] delta = {1'b0, new_sample} - {1'b0, prev_sample}; // signed step
	wire [16:0] dc_diff = {1'b0, new_sample} - {1'b0, sensor_dc_level}; // offset from dc
	wire [15:0] delta_mag = mag17(delta); // step size
	wire [15:0] prev_mag = mag17(prev_delta); // previous step size
	wire [15:0] dc_mag = mag17(dc_diff); // excursion size
	wire [6:0] trans_field = transient_sensitivity[6:0]; // transient level
	wire [6:0] noise_field = noise_sensitivity[6:0]; // noise level
	wire [1:0] win_code = advanced_control_two[WSIZE_LSB +: 2]; // window size field
	logic [15:0] win_width; // half width of the control window

	// RL14 window size decode
	always_comb begin
		unique case (mtr_win_type'(win_code))
			WIN_SMALL: win_width = WIN_SMALL_WIDTH;
			WIN_MEDIUM: win_width = WIN_MEDIUM_WIDTH;
			WIN_LARGE: win_width = WIN_LARGE_WIDTH;
			WIN_RESERVED: win_width = 16'hFFFF;
		endcase
	end

	// reserved window code never leaves the window
	assign out_of_window = (win_code != WIN_RESERVED) && (dc_mag > win_width);
	// RL7 transient zero disables
	wire transient_hit = avg_bus.valid && have_prev && (trans_field != 7'h00)
		&& (delta_mag > {9'h000, trans_field});
	// RL8 noise zero disables
	wire noise_hit = avg_bus.valid && have_prev && (noise_field != 7'h00)
		&& (delta[16] != prev_delta[16]) && (delta_mag > {9'h000, noise_field})
		&& (prev_mag > {9'h000, noise_field});
	// RL1 process rate low flag
	wire rate_low = engine_process_rate < RATE_LOW_LIMIT;

	// ****************************************
	// bus decode
	// ****************************************
	wire [7:0] idx = adr_i[9:2]; // word index
	wire upper_zero = adr_i[31:10] == 22'h000000; // only the low window is mapped
	wire req = cyc_i && stb_i && !ack_o; // new bus request
	wire wr = req && we_i && sel_i[0]; // byte lane zero write
	wire rd = req && !we_i; // read access
	wire wr_size = wr && upper_zero && (idx == IDX_SIZE);
	wire wr_deb = wr && upper_zero && (idx == IDX_DEBOUNCE);
	wire wr_batch = wr && upper_zero && (idx == IDX_BATCH);
	wire wr_trans = wr && upper_zero && (idx == IDX_TRANSIENT);
	wire wr_noise = wr && upper_zero && (idx == IDX_NOISE);
	wire wr_ctrl2 = wr && upper_zero && (idx == IDX_CTRL2);
	wire wr_mask = wr && upper_zero && (idx == IDX_IRQ_MASK);
	wire wr_sens = wr && upper_zero && (idx == IDX_SENS);
	wire wr_status = wr && upper_zero && (idx == IDX_STATUS);
	wire rd_sig_hi = rd && upper_zero && (idx == IDX_SIG_HI);
	wire rd_dc_hi = rd && upper_zero && (idx == IDX_DC_HI);
	wire rd_rate_hi = rd && upper_zero && (idx == IDX_RATE_HI);
	logic [7:0] rd_byte; // selected read byte

	// read selection, unmapped reads return zero
	always_comb begin
		rd_byte = 8'h00;
		if (upper_zero) begin
			unique case (idx)
				IDX_STATUS: rd_byte = status;
				IDX_CTRL2: rd_byte = advanced_control_two;
				IDX_RATE_HI: rd_byte = engine_process_rate[15:8];
				IDX_RATE_LO: rd_byte = low_shadow;
				IDX_SIZE: rd_byte = sample_averaging_size;
				IDX_DEBOUNCE: rd_byte = debounce_time;
				IDX_BATCH: rd_byte = debounce_batch_mask;
				// RL12 bit seven reads zero
				IDX_TRANSIENT: rd_byte = transient_sensitivity & SENSE_FIELD;
				IDX_NOISE: rd_byte = noise_sensitivity & SENSE_FIELD;
				IDX_SIG_HI: rd_byte = sensor_sample_value[15:8];
				IDX_SIG_LO: rd_byte = low_shadow;
				IDX_DC_HI: rd_byte = sensor_dc_level[15:8];
				IDX_DC_LO: rd_byte = low_shadow;
				IDX_IRQ_MASK: rd_byte = irq_mask;
				IDX_SENS: rd_byte = motion_sensitivity;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// ****************************************
	// bus answer
	// ****************************************
	// single-cycle ack, data registered with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			if (rd) begin
				dat_o <= {24'h000000, rd_byte};
			end
		end
	end

	// RL2 high read captures low byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_shadow <= 8'h00;
		end else if (rd_sig_hi) begin
			low_shadow <= sensor_sample_value[7:0];
		end else if (rd_dc_hi) begin
			low_shadow <= sensor_dc_level[7:0];
		end else if (rd_rate_hi) begin
			low_shadow <= engine_process_rate[7:0];
		end
	end

	// ****************************************
	// tuning registers
	// ****************************************
	// software-written settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_averaging_size <= RST_SIZE;
			debounce_time <= RST_DEBOUNCE;
			debounce_batch_mask <= RST_BATCH;
			transient_sensitivity <= RST_SENSE;
			noise_sensitivity <= RST_SENSE;
			motion_sensitivity <= RST_SENSE;
			advanced_control_two <= RST_CTRL2;
			irq_mask <= 8'h00;
		end else begin
			if (wr_size) sample_averaging_size <= dat_i[7:0];
			// RL4 debounce time stored
			if (wr_deb) debounce_time <= dat_i[7:0];
			// RL6 batch mask stored
			if (wr_batch) debounce_batch_mask <= dat_i[7:0];
			// RL12 bit seven ignores writes
			if (wr_trans) transient_sensitivity <= dat_i[7:0] & SENSE_FIELD;
			if (wr_noise) noise_sensitivity <= dat_i[7:0] & SENSE_FIELD;
			if (wr_sens) motion_sensitivity <= dat_i[7:0];
			if (wr_ctrl2) advanced_control_two <= dat_i[7:0];
			if (wr_mask) irq_mask <= dat_i[7:0] & STATUS_MASK;
		end
	end

	// ****************************************
	// engine results
	// ****************************************
	// sample, dc level and process rate capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sensor_sample_value <= 16'h0000;
			sensor_dc_level <= 16'h0000;
			engine_process_rate <= 16'h0000;
			prev_sample <= 16'h0000;
			prev_delta <= 17'h00000;
			have_prev <= 1'b0;
		end else begin
			// RL1 process rate tracked
			engine_process_rate <= process_rate_i;
			// RL10 store new sample
			if (avg_bus.valid) begin
				sensor_sample_value <= new_sample;
				prev_sample <= new_sample;
				prev_delta <= have_prev ? delta : 17'h00000;
				have_prev <= 1'b1;
			end
			// RL11 store dc level
			if (dc_valid_i) begin
				sensor_dc_level <= dc_i;
			end
		end
	end

	// ****************************************
	// status and interrupt
	// ****************************************
	logic [7:0] set_bits; // events this cycle

	// gather events into status positions
	always_comb begin
		set_bits = 8'h00;
		set_bits[ST_TRANSIENT] = transient_hit;
		set_bits[ST_NOISE] = noise_hit;
		// RL13 device sets new-sample flag
		set_bits[ST_NEW_SAMPLE] = avg_bus.valid;
		set_bits[ST_MOTION] = motion_pulse;
		set_bits[ST_RATE_LOW] = rate_low;
	end

	// sticky flags, write one clears, a set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= 8'h00;
		end else begin
			// RL13 software clears by writing one
			status <= ((status & ~(wr_status ? dat_i[7:0] : 8'h00)) | set_bits) & STATUS_MASK;
		end
	end

	// registered side outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			rate_low_o <= 1'b0;
			motion_o <= 1'b0;
		end else begin
			irq_o <= |(status & irq_mask);
			rate_low_o <= rate_low;
			motion_o <= motion_pulse;
		end
	end

endmodule : mtr_tuning_regs

/* File: mtr_pkg.sv */
package mtr_pkg;

	// ****************************************
	// register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_STATUS = 8'hF0;
	localparam logic [7:0] IDX_CTRL2 = 8'hF2;
	localparam logic [7:0] IDX_RATE_HI = 8'hF3;
	localparam logic [7:0] IDX_RATE_LO = 8'hF4;
	localparam logic [7:0] IDX_SIZE = 8'hF5;
	localparam logic [7:0] IDX_DEBOUNCE = 8'hF6;
	localparam logic [7:0] IDX_BATCH = 8'hF7;
	localparam logic [7:0] IDX_TRANSIENT = 8'hF8;
	localparam logic [7:0] IDX_NOISE = 8'hF9;
	localparam logic [7:0] IDX_SIG_HI = 8'hFA;
	localparam logic [7:0] IDX_SIG_LO = 8'hFB;
	localparam logic [7:0] IDX_DC_HI = 8'hFC;
	localparam logic [7:0] IDX_DC_LO = 8'hFD;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hE0;
	localparam logic [7:0] IDX_SENS = 8'hE1;

	// ****************************************
	// field layouts
	// ****************************************
	localparam int ST_TRANSIENT = 0;
	localparam int ST_NOISE = 1;
	localparam int ST_NEW_SAMPLE = 3;
	localparam int ST_MOTION = 5;
	localparam int ST_RATE_LOW = 6;
	localparam logic [7:0] STATUS_MASK = 8'h6B;
	localparam logic [7:0] SENSE_FIELD = 8'h7F;
	localparam int WSIZE_LSB = 3;

	// ****************************************
	// reset values and thresholds
	// ****************************************
	localparam logic [7:0] RST_SIZE = 8'h01;
	localparam logic [7:0] RST_DEBOUNCE = 8'h01;
	localparam logic [7:0] RST_BATCH = 8'h01;
	localparam logic [7:0] RST_SENSE = 8'h00;
	localparam logic [7:0] RST_CTRL2 = 8'h08;
	localparam logic [15:0] RATE_LOW_LIMIT = 16'h0080;

	// window size codes
	typedef enum logic [1:0] {
		WIN_RESERVED = 2'h0,
		WIN_SMALL = 2'h1,
		WIN_MEDIUM = 2'h2,
		WIN_LARGE = 2'h3
	} mtr_win_type;

endpackage : mtr_pkg

/* File: mtr_sample_if.sv */
// averaged sample stream between the averager and the register bank
interface mtr_sample_if;
	logic valid; // one-cycle strobe of a new sample
	logic [15:0] data; // averaged sample
	modport src (output valid, output data);
	modport dst (input valid, input data);
endinterface : mtr_sample_if

/* File: mtr_averager.sv */
module mtr_averager
	import mtr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic adc_valid_i,
	input wire logic [15:0] adc_i,
	input wire logic [7:0] size_i,
	mtr_sample_if.src out
);

	// ****************************************
	// block averaging with a serial divider
	// ****************************************
	typedef enum logic [1:0] {
		AV_ACC = 2'b00,
		AV_DIV = 2'b01,
		AV_OUT = 2'b11
	} mtr_av_type;

	mtr_av_type state; // averager phase
	logic [23:0] sum; // running sum, then quotient
	logic [8:0] rem; // division remainder
	logic [7:0] cnt; // samples taken
	logic [7:0] divisor; // latched block size
	logic [4:0] bit_cnt; // divider steps left
	logic [15:0] result; // last average
	logic res_valid; // result strobe
	wire [7:0] size_eff = (size_i == 8'h00) ? 8'h01 : size_i; // zero acts as one
	wire [8:0] trial = {rem[7:0], sum[23]}; // next partial remainder
	wire fits = trial >= {1'b0, divisor}; // subtract step

	assign out.valid = res_valid;
	assign out.data = result;

	// accumulate, divide, publish
	always_ff @(posedge clk_i) begin
		res_valid <= 1'b0;
		if (rst_i) begin
			state <= AV_ACC;
			sum <= 24'h000000;
			rem <= 9'h000;
			cnt <= 8'h00;
			divisor <= 8'h01;
			bit_cnt <= 5'h00;
			result <= 16'h0000;
		end else begin
			unique case (state)
				AV_ACC: begin
					// RL3 average by size
					if (adc_valid_i) begin
						sum <= sum + {8'h00, adc_i};
						if (cnt + 8'h01 >= size_eff) begin
							cnt <= 8'h00;
							divisor <= size_eff;
							rem <= 9'h000;
							bit_cnt <= 5'd24;
							state <= AV_DIV;
						end else begin
							cnt <= cnt + 8'h01;
						end
					end
				end
				AV_DIV: begin
					rem <= fits ? (trial - {1'b0, divisor}) : trial;
					sum <= {sum[22:0], fits};
					bit_cnt <= bit_cnt - 5'h01;
					if (bit_cnt == 5'h01) begin
						state <= AV_OUT;
					end
				end
				AV_OUT: begin
					result <= sum[15:0];
					res_valid <= 1'b1;
					sum <= 24'h000000;
					state <= AV_ACC;
				end
			endcase
		end
	end

endmodule : mtr_averager

/* File: mtr_debounce.sv */
module mtr_debounce
	import mtr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sample_valid_i,
	input wire logic out_of_window_i,
	input wire logic [7:0] batch_mask_i,
	input wire logic [7:0] debounce_time_i,
	input wire logic [7:0] sensitivity_i,
	output logic motion_o
);

	// ****************************************
	// out-of-window batching and debounce count
	// ****************************************
	logic [7:0] hist; // recent out-of-window history
	logic [7:0] count; // valid debounce counts
	wire [7:0] next_hist = {hist[6:0], out_of_window_i}; // history with this sample
	// RL6 mask forms one batch
	wire batch_done = (next_hist & batch_mask_i) == batch_mask_i;
	// RL5 short debounce disables detection
	wire enabled = debounce_time_i >= sensitivity_i;
	// RL4 wait debounce time
	wire reached = batch_done && (count + 8'h01 >= debounce_time_i);

	// track batches and raise motion
	always_ff @(posedge clk_i) begin
		motion_o <= 1'b0;
		if (rst_i) begin
			hist <= 8'h00;
			count <= 8'h00;
		end else if (sample_valid_i) begin
			if (!out_of_window_i) begin
				// back in window: start over
				hist <= 8'h00;
				count <= 8'h00;
			end else if (reached) begin
				hist <= 8'h00;
				count <= 8'h00;
				motion_o <= enabled;
			end else if (batch_done) begin
				hist <= 8'h00;
				count <= count + 8'h01;
			end else begin
				hist <= next_hist;
			end
		end
	end

endmodule : mtr_debounce

/* File: mtr_tuning_regs_asserts.sv */
// ****************************************
// port checker for the tuning register bank
// ****************************************
module mtr_tuning_regs_asserts
	import mtr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic adc_valid_i,
	input wire logic [15:0] adc_i,
	input wire logic dc_valid_i,
	input wire logic [15:0] dc_i,
	input wire logic [15:0] process_rate_i,
	input wire logic rate_low_o,
	input wire logic motion_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// live bus request
	wire logic req = cyc_i && stb_i;
	// answer to a read
	wire logic rd_ack = ack_o && !we_i;
	// address of the transient or noise sensitivity register
	wire logic sense_idx = (adr_i[9:2] == IDX_TRANSIENT) || (adr_i[9:2] == IDX_NOISE);
	// ****************************************
	// bus handshake
	// ****************************************
	a_ack_taken: assert property (req && !ack_o |=> ack_o) else $error("request not acknowledged");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_cause: assert property (!req |=> !ack_o) else $error("ack without request");
	a_dat_hold: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved without ack");
	a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits not zero");
	a_unmapped_zero: assert property (rd_ack && adr_i[31:10] != 22'h0 |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	// ****************************************
	// register and engine outputs
	// ****************************************
	a_reserved_bit_zero: assert property (rd_ack && sense_idx |-> !dat_o[7]) else $error("bit seven set");
	a_rate_low_set: assert property ((process_rate_i < RATE_LOW_LIMIT)[*3] |-> rate_low_o)
		else $error("rate low flag missing");
	a_rate_ok_clear: assert property ((!rst_i && process_rate_i >= RATE_LOW_LIMIT)[*3] |-> !rate_low_o)
		else $error("rate low flag wrong");
	a_motion_pulse: assert property (motion_o |=> !motion_o) else $error("motion pulse too long");
	// main scenarios seen
	c_sense_read: cover property (rd_ack && sense_idx);
	c_motion: cover property (motion_o);
	c_irq: cover property (irq_o ##1 !irq_o);
	c_rate_low: cover property (rate_low_o ##1 !rate_low_o);
endmodule : mtr_tuning_regs_asserts

bind mtr_tuning_regs mtr_tuning_regs_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.adc_valid_i(adc_valid_i), .adc_i(adc_i), .dc_valid_i(dc_valid_i), .dc_i(dc_i),
	.process_rate_i(process_rate_i), .rate_low_o(rate_low_o), .motion_o(motion_o), .irq_o(irq_o));

/* File: mtr_tuning_regs_test.sv */
module mtr_tuning_regs_test import mtr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic adc_valid_i = 1'b0, dc_valid_i = 1'b0;
	logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
	logic [3:0] sel_i = 4'h0;
	logic [15:0] adc_i = 16'h0, dc_i = 16'h0, process_rate_i = 16'h0100;
	logic ack_o, rate_low_o, motion_o, irq_o;
	logic [7:0] q; // last read byte
	logic [15:0] motions = 16'h0000; // motion pulses seen
	int mismatches = 0, compares = 0, cycles = 0;
	// tables for the plain registers
	logic [7:0] ridx [5] = '{IDX_SIZE, IDX_DEBOUNCE, IDX_BATCH, IDX_TRANSIENT, IDX_NOISE};
	logic [7:0] rval [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
	logic [7:0] wval [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F};
	// window codes, order keeps history clean
	logic [1:0] wcode [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
	logic [7:0] wexp [4] = '{8'h00, 8'h00, 8'h20, 8'h20};

	mtr_tuning_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .adc_valid_i(adc_valid_i), .adc_i(adc_i),
		.dc_valid_i(dc_valid_i), .dc_i(dc_i), .process_rate_i(process_rate_i), .rate_low_o(rate_low_o),
		.motion_o(motion_o), .irq_o(irq_o));

	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	// count motion pulses on the pin
	always @(posedge clk_i) begin
		if (motion_o === 1'b1) motions <= motions + 16'h0001;
	end
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			results();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] ba(input logic [7:0] i);
		return {22'h0, i, 2'h0};
	endfunction : ba
	task results;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one classic single cycle, held until ack
	task wb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		sel_i <= s;
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb
	task wr(input logic [31:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr
	task rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
		wb(1'b0, a, 8'h00, 4'hF);
		chk({8'h0, q & m}, {8'h0, e});
	endtask : rd
	// one converter pulse, then time for the engine
	task smp(input logic [15:0] v);
		@(posedge clk_i);
		adc_valid_i <= 1'b1;
		adc_i <= v;
		@(posedge clk_i);
		adc_valid_i <= 1'b0;
		repeat (32) @(posedge clk_i);
	endtask : smp
	task dcw(input logic [15:0] v);
		@(posedge clk_i);
		dc_valid_i <= 1'b1;
		dc_i <= v;
		@(posedge clk_i);
		dc_valid_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : dcw
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ridx[i]) begin
			rd(ba(ridx[i]), 8'hFF, rval[i]);
			wr(ba(ridx[i]), 8'hFF);
			rd(ba(ridx[i]), 8'hFF, wval[i]);
			wb(1'b1, ba(ridx[i]), 8'h00, 4'hE);
			rd(ba(ridx[i]), 8'hFF, wval[i]);
		end
		wr(32'h0000_07D4, 8'hAA);
		rd(32'h0000_07D4, 8'hFF, 8'h00);
		rd(ba(IDX_SIZE), 8'hFF, 8'hFF);
		rd(ba(8'h10), 8'hFF, 8'h00);
		wr(ba(IDX_SIG_HI), 8'h55);
		rd(ba(IDX_SIG_HI), 8'hFF, 8'h00);
		rd(ba(IDX_SIG_LO), 8'hFF, 8'h00);
		$display("register access test done");
		process_rate_i <= 16'h1234;
		repeat (3) @(posedge clk_i);
		rd(ba(IDX_RATE_HI), 8'hFF, 8'h12);
		rd(ba(IDX_RATE_LO), 8'hFF, 8'h34);
		process_rate_i <= 16'h007F;
		repeat (3) @(posedge clk_i);
		chk({15'h0, rate_low_o}, 16'h0001);
		rd(ba(IDX_STATUS), 8'h40, 8'h40);
		process_rate_i <= 16'h0080;
		repeat (3) @(posedge clk_i);
		chk({15'h0, rate_low_o}, 16'h0000);
		wr(ba(IDX_STATUS), 8'hFF);
		rd(ba(IDX_STATUS), 8'hFF, 8'h00);
		$display("process rate test done");
		wr(ba(IDX_SIZE), 8'h01);
		wr(ba(IDX_DEBOUNCE), 8'h01);
		wr(ba(IDX_BATCH), 8'h01);
		wr(ba(IDX_TRANSIENT), 8'h00);
		wr(ba(IDX_NOISE), 8'h00);
		wr(ba(IDX_SENS), 8'h00);
		wr(ba(IDX_IRQ_MASK), 8'h08);
		dcw(16'h3C5A);
		rd(ba(IDX_DC_HI), 8'hFF, 8'h3C);
		rd(ba(IDX_DC_LO), 8'hFF, 8'h5A);
		dcw(16'h0000);
		smp(16'hA5C3);
		rd(ba(IDX_STATUS), 8'h08, 8'h08);
		chk({15'h0, irq_o}, 16'h0001);
		rd(ba(IDX_SIG_HI), 8'hFF, 8'hA5);
		rd(ba(IDX_SIG_LO), 8'hFF, 8'hC3);
		wr(ba(IDX_IRQ_MASK), 8'h00);
		repeat (2) @(posedge clk_i);
		chk({15'h0, irq_o}, 16'h0000);
		wr(ba(IDX_IRQ_MASK), 8'h08);
		repeat (2) @(posedge clk_i);
		chk({15'h0, irq_o}, 16'h0001);
		wr(ba(IDX_STATUS), 8'hFF);
		repeat (2) @(posedge clk_i);
		chk({15'h0, irq_o}, 16'h0000);
		rd(ba(IDX_STATUS), 8'h08, 8'h00);
		$display("sample and interrupt test done");
		wr(ba(IDX_SIZE), 8'h02);
		smp(16'h0040);
		rd(ba(IDX_STATUS), 8'h08, 8'h00);
		smp(16'h0060);
		rd(ba(IDX_STATUS), 8'h08, 8'h08);
		rd(ba(IDX_SIG_HI), 8'hFF, 8'h00);
		rd(ba(IDX_SIG_LO), 8'hFF, 8'h50);
		wr(ba(IDX_SIZE), 8'h01);
		smp(16'h0000);
		foreach (wcode[i]) begin
			wr(ba(IDX_CTRL2), {3'h0, wcode[i], 3'h0});
			wr(ba(IDX_STATUS), 8'hFF);
			smp(16'h0090);
			smp(16'h0090);
			rd(ba(IDX_STATUS), 8'h20, wexp[i]);
		end
		wr(ba(IDX_CTRL2), 8'h08);
		smp(16'h0000);
		wr(ba(IDX_BATCH), 8'h03);
		wr(ba(IDX_STATUS), 8'hFF);
		smp(16'h0090);
		rd(ba(IDX_STATUS), 8'h20, 8'h00);
		smp(16'h0090);
		rd(ba(IDX_STATUS), 8'h20, 8'h20);
		smp(16'h0000);
		wr(ba(IDX_BATCH), 8'h01);
		wr(ba(IDX_SENS), 8'h02);
		wr(ba(IDX_STATUS), 8'hFF);
		smp(16'h0090);
		smp(16'h0090);
		rd(ba(IDX_STATUS), 8'h20, 8'h00);
		wr(ba(IDX_DEBOUNCE), 8'h02);
		smp(16'h0000);
		wr(ba(IDX_STATUS), 8'hFF);
		smp(16'h0090);
		rd(ba(IDX_STATUS), 8'h20, 8'h00);
		smp(16'h0090);
		rd(ba(IDX_STATUS), 8'h20, 8'h20);
		$display("motion test done");
		wr(ba(IDX_TRANSIENT), 8'h10);
		smp(16'h0000);
		wr(ba(IDX_STATUS), 8'hFF);
		smp(16'h0030);
		rd(ba(IDX_STATUS), 8'h01, 8'h01);
		wr(ba(IDX_NOISE), 8'h08);
		wr(ba(IDX_STATUS), 8'hFF);
		smp(16'h0000);
		smp(16'h0030);
		rd(ba(IDX_STATUS), 8'h02, 8'h02);
		$display("transient and noise test done");
		chk(motions, 16'h0008);
		results();
	end
endmodule : mtr_tuning_regs_test
